// ---- dtio_contact_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// contact bank: switches closing to common
module dtio_contact_model #(
    parameter int BOUNCE = 3
) (
    // clock
    input  wire logic       clk_i,
    // closures asked for by the bench
    input  wire logic [7:0] want_i,
    // contact levels, 1 = closed to common
    output logic      [7:0] contact_o
);
    logic [7:0] want_q = 8'h00;
    logic [7:0] chg_q  = 8'h00;
    logic [3:0] cnt_q  = 4'h0;
    initial contact_o = 8'h00;
    // dry contact: only closed or open, never a driven voltage; chatters on every change
    always @(posedge clk_i) begin
        if (want_i != want_q) begin
            want_q    <= want_i;
            chg_q     <= want_i ^ want_q;
            cnt_q     <= 4'(BOUNCE);
            contact_o <= want_i;
        end else if (cnt_q != 4'h0) begin
            cnt_q     <= cnt_q - 4'h1;
            contact_o <= (cnt_q == 4'h1) ? want_q : contact_o ^ chg_q;
        end
    end
endmodule : dtio_contact_model
`default_nettype wire

// ---- dtio_debounce.sv ----
`timescale 1ns/100ps
`default_nettype none
module dtio_debounce #(
    parameter int N   = 8,
    parameter int CNT = 200
) (
    // clock
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         en_i,
    // contacts
    input  wire logic [N-1:0] raw_i,
    output logic      [N-1:0] clean_o
);
    // ==========================================
    // two-flop sync then stable-count filter
    localparam int CW = $clog2(CNT + 1);
    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else if (en_i) begin
            s1_q <= raw_i;
            s2_q <= s1_q;
        end
    end
    for (genvar g = 0; g < N; g++) begin : g_ch
        logic [CW-1:0] cnt_q;
        logic          out_q;
        wire           diff = s2_q[g] != out_q;
        wire           done = cnt_q == CW'(CNT - 1);
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cnt_q <= '0;
                out_q <= 1'b0;
            end else if (en_i) begin
                cnt_q <= (diff && !done) ? cnt_q + 1'b1 : '0;
                if (diff && done) out_q <= s2_q[g];
            end
        end
        assign clean_o[g] = out_q;
    end
endmodule : dtio_debounce
`default_nettype wire

// ---- dtio_map.svh ----
`ifndef DTIO_MAP_SVH
`define DTIO_MAP_SVH
// ==========================================
// register offsets (word addresses)
`define DTIO_OFF_CTRL      4'h0
`define DTIO_OFF_ZERO_LVL  4'h1
`define DTIO_OFF_DET_FREQ  4'h2
`define DTIO_OFF_OVL_LVL   4'h3
`define DTIO_OFF_RUN_LVL   4'h4
`define DTIO_OFF_PRESET0   4'h5
`define DTIO_OFF_PRESET1   4'h6
`define DTIO_OFF_PRESET2   4'h7
`define DTIO_OFF_PRESET3   4'h8
`define DTIO_OFF_INCH      4'h9
`define DTIO_OFF_STATUS    4'ha
`define DTIO_OFF_FREQ      4'hb
`define DTIO_OFF_LOAD      4'hc
// ==========================================
// fields and reset values
`define DTIO_STAT_RUN      0
`define DTIO_STAT_REV      1
`define DTIO_STAT_TRIP     2
`define DTIO_STAT_COAST    3
`define DTIO_FAULT_EXT     8'h1d
`define DTIO_RST_LVL       16'h0000
// ==========================================
// timing
`define DTIO_DEB_US        5
`define DTIO_CLK_MHZ       40
`endif

// ---- dtio_pkg.sv ----
`default_nettype none
package dtio_pkg;
    typedef enum logic [1:0] {
        DTIO_STOP,
        DTIO_FWD,
        DTIO_REV
    } dtio_dir_t;
    typedef enum logic [1:0] {
        DTIO_IDLE,
        DTIO_RUN,
        DTIO_COAST,
        DTIO_TRIP
    } dtio_state_t;
endpackage : dtio_pkg
`default_nettype wire

// ---- dtio_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtio_map.svh"
module dtio_regs #(
    parameter int W = 16
) (
    // clock
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         en_i,
    // write port
    input  wire logic         wr_i,
    input  wire logic [3:0]   waddr_i,
    input  wire logic [W-1:0] wdata_i,
    // read port
    input  wire logic [3:0]   raddr_i,
    output logic      [W-1:0] rdata_o
);
    // ==========================================
    // small settings memory, registered read
    logic [W-1:0] mem_q [10];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 10; i++) mem_q[i] <= `DTIO_RST_LVL;
            rdata_o <= '0;
        end else if (en_i) begin
            // slot 0 is the unused control word, so writes there are dropped
            if (wr_i && waddr_i != 4'h0 && waddr_i < 4'ha) mem_q[waddr_i] <= wdata_i;
            rdata_o <= (raddr_i < 4'ha) ? mem_q[raddr_i] : '0;
        end
    end
endmodule : dtio_regs
`default_nettype wire

// ---- dtio_top.sv ----
// Overview of operation
// - a closed forward contact runs the motor forward and opening it stops the motor.
// - a closed reverse contact runs the motor in reverse and opening it stops the motor.
// - an external fault trips the drive, stops the motor and records fault code 29.
// - the fault clear input releases the latched trip, which otherwise persists.
// - the two speed-select inputs form a binary code choosing one of four preset speeds.
// - while the inch input is active a closed run contact runs the drive at the inch frequency.
// - coast stop removes the drive output at once and lets the motor coast.
// - zero speed is shown while stopped or while frequency is below the zero-speed level.
// - frequency reached is shown while the output frequency exceeds the detection level.
// - overload warning is shown while the measured load exceeds the overload level.
// - on a trip the fault relay closes its normally-open and opens its normally-closed contact.
// - while running above the run level the run relay closes normally-open, opens normally-closed.
`timescale 1ns/100ps
`default_nettype none
`include "dtio_map.svh"
module dtio_top #(
    parameter int W       = 16,
    parameter int DEB_CNT = `DTIO_DEB_US * `DTIO_CLK_MHZ
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         clk_en_i,
    // contact inputs, closed to common = 1
    input  wire logic         fwd_run_in_i,
    input  wire logic         rev_run_in_i,
    input  wire logic         ext_fault_in_i,
    input  wire logic         fault_clear_in_i,
    input  wire logic         speed_sel0_in_i,
    input  wire logic         speed_sel1_in_i,
    input  wire logic         inch_in_i,
    input  wire logic         coast_stop_in_i,
    // drive feedback, same clock
    input  wire logic [W-1:0] out_freq_i,
    input  wire logic [W-1:0] out_load_i,
    // register port
    input  wire logic [3:0]   reg_addr_i,
    input  wire logic [W-1:0] reg_wdata_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    output logic      [W-1:0] reg_rdata_o,
    // drive command
    output logic              drive_en_o,
    output logic              drive_rev_o,
    output logic      [W-1:0] freq_cmd_o,
    output logic      [7:0]   fault_code_o,
    // status outputs
    output logic              zero_speed_out_o,
    output logic              freq_reached_out_o,
    output logic              overload_warn_out_o,
    // relay contacts, 1 = closed to common
    output logic              fault_relay_no_o,
    output logic              fault_relay_nc_o,
    output logic              run_relay_no_o,
    output logic              run_relay_nc_o
);
    // ==========================================
    // reset release
    logic rs1_q;
    logic rst_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rs1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_q <= rs1_q;
        end
    end
    wire rst_b = rst_q;

    // ==========================================
    // contact conditioning
    logic [7:0] pins;
    logic [7:0] cin;
    assign pins = {coast_stop_in_i, inch_in_i, speed_sel1_in_i, speed_sel0_in_i,
                   fault_clear_in_i, ext_fault_in_i, rev_run_in_i, fwd_run_in_i};
    dtio_debounce #(
        .N   (8),
        .CNT (DEB_CNT)
    ) u_deb (
        .clk_i   (clk_i),
        .rst_b_i (rst_b),
        .en_i    (clk_en_i),
        .raw_i   (pins),
        .clean_o (cin)
    );
    wire fwd   = cin[0];
    wire rev   = cin[1];
    wire efl   = cin[2];
    wire fclr  = cin[3];
    wire [1:0] sel = cin[5:4];
    wire inch  = cin[6];
    wire coast = cin[7];

    // ==========================================
    // settings memory and live registers
    logic [W-1:0] mem_rd;
    logic [W-1:0] zero_lvl_q;
    logic [W-1:0] det_q;
    logic [W-1:0] ovl_q;
    logic [W-1:0] run_lvl_q;
    logic [W-1:0] pre_q [4];
    logic [W-1:0] inch_q;
    wire  wr = reg_wr_i && clk_en_i;
    dtio_regs #(
        .W (W)
    ) u_regs (
        .clk_i   (clk_i),
        .rst_b_i (rst_b),
        .en_i    (clk_en_i),
        .wr_i    (reg_wr_i),
        .waddr_i (reg_addr_i),
        .wdata_i (reg_wdata_i),
        .raddr_i (reg_addr_i),
        .rdata_o (mem_rd)
    );
    // shadow copies so comparators see settings without a read port each
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            zero_lvl_q <= `DTIO_RST_LVL;
            det_q      <= `DTIO_RST_LVL;
            ovl_q      <= `DTIO_RST_LVL;
            run_lvl_q  <= `DTIO_RST_LVL;
            inch_q     <= `DTIO_RST_LVL;
            for (int i = 0; i < 4; i++) pre_q[i] <= `DTIO_RST_LVL;
        end else if (wr) begin
            case (reg_addr_i)
                `DTIO_OFF_ZERO_LVL: zero_lvl_q <= reg_wdata_i;
                `DTIO_OFF_DET_FREQ: det_q      <= reg_wdata_i;
                `DTIO_OFF_OVL_LVL:  ovl_q      <= reg_wdata_i;
                `DTIO_OFF_RUN_LVL:  run_lvl_q  <= reg_wdata_i;
                `DTIO_OFF_PRESET0:  pre_q[0]   <= reg_wdata_i;
                `DTIO_OFF_PRESET1:  pre_q[1]   <= reg_wdata_i;
                `DTIO_OFF_PRESET2:  pre_q[2]   <= reg_wdata_i;
                `DTIO_OFF_PRESET3:  pre_q[3]   <= reg_wdata_i;
                `DTIO_OFF_INCH:     inch_q     <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ==========================================
    // run state machine
    dtio_pkg::dtio_state_t st_q;
    dtio_pkg::dtio_state_t st_d;
    logic                  trip_q;
    logic [7:0]            code_q;
    wire fwd_only = fwd && !rev;
    wire rev_only = rev && !fwd;
    wire run_req  = fwd_only || rev_only;
    always_comb begin
        st_d = st_q;
        case (st_q)
            dtio_pkg::DTIO_IDLE:  if (run_req) st_d = dtio_pkg::DTIO_RUN;
            dtio_pkg::DTIO_RUN:   if (!run_req) st_d = dtio_pkg::DTIO_IDLE;
            dtio_pkg::DTIO_COAST: if (!coast) st_d = dtio_pkg::DTIO_IDLE;
            dtio_pkg::DTIO_TRIP:  if (!trip_q) st_d = dtio_pkg::DTIO_IDLE;
            default:              st_d = dtio_pkg::DTIO_IDLE;
        endcase
        if (coast && st_q != dtio_pkg::DTIO_TRIP) st_d = dtio_pkg::DTIO_COAST;
        if (efl || trip_q) st_d = dtio_pkg::DTIO_TRIP;
    end
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= dtio_pkg::DTIO_IDLE;
            trip_q <= 1'b0;
            code_q <= 8'h00;
        end else if (clk_en_i) begin
            st_q <= st_d;
            // fault wins over clear so a fresh fault is never lost
            if (efl) begin
                trip_q <= 1'b1;
                code_q <= `DTIO_FAULT_EXT;
            end else if (fclr) begin
                trip_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // frequency selection and drive command
    wire          running = st_q == dtio_pkg::DTIO_RUN;
    wire [W-1:0]  fsel    = inch ? inch_q : pre_q[sel];
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            drive_en_o   <= 1'b0;
            drive_rev_o  <= 1'b0;
            freq_cmd_o   <= '0;
            fault_code_o <= 8'h00;
        end else if (clk_en_i) begin
            drive_en_o   <= st_d == dtio_pkg::DTIO_RUN;
            drive_rev_o  <= rev_only;
            freq_cmd_o   <= (st_d == dtio_pkg::DTIO_RUN) ? fsel : '0;
            fault_code_o <= code_q;
        end
    end

    // ==========================================
    // status outputs and relays
    function automatic logic dtio_above(input logic [W-1:0] v, input logic [W-1:0] lvl);
        dtio_above = v > lvl;
    endfunction : dtio_above
    wire over_det  = dtio_above(out_freq_i, det_q);
    wire over_run  = dtio_above(out_freq_i, run_lvl_q);
    wire over_ovl  = dtio_above(out_load_i, ovl_q);
    wire over_zero = dtio_above(zero_lvl_q, out_freq_i);
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            zero_speed_out_o    <= 1'b0;
            freq_reached_out_o  <= 1'b0;
            overload_warn_out_o <= 1'b0;
            fault_relay_no_o    <= 1'b0;
            fault_relay_nc_o    <= 1'b1;
            run_relay_no_o      <= 1'b0;
            run_relay_nc_o      <= 1'b1;
        end else if (clk_en_i) begin
            zero_speed_out_o    <= !running || over_zero;
            freq_reached_out_o  <= over_det;
            overload_warn_out_o <= over_ovl;
            fault_relay_no_o    <= trip_q;
            fault_relay_nc_o    <= !trip_q;
            run_relay_no_o      <= running && over_run;
            run_relay_nc_o      <= !(running && over_run);
        end
    end

    // ==========================================
    // register read mux
    logic          rd_q;
    logic [3:0]    ra_q;
    logic [W-1:0]  live_q;
    wire  [W-1:0]  status = W'({code_q, 4'h0, coast, trip_q, drive_rev_o, running});
    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            rd_q   <= 1'b0;
            ra_q   <= 4'h0;
            live_q <= '0;
        end else if (clk_en_i) begin
            rd_q <= reg_rd_i;
            ra_q <= reg_addr_i;
            case (reg_addr_i)
                `DTIO_OFF_STATUS: live_q <= status;
                `DTIO_OFF_FREQ:   live_q <= out_freq_i;
                `DTIO_OFF_LOAD:   live_q <= out_load_i;
                default:          live_q <= '0;
            endcase
        end
    end
    wire live_sel = ra_q >= `DTIO_OFF_STATUS;
    assign reg_rdata_o = !rd_q ? '0 : (live_sel ? live_q : mem_rd);
endmodule : dtio_top
`default_nettype wire

// ---- dtio_top_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtio_map.svh"
module dtio_top_chk #(
    parameter int W       = 16,
    parameter int DEB_CNT = 4
) (
    // clock and reset
    input wire logic         clk_i,
    input wire logic         rst_b_i,
    // contacts
    input wire logic         fwd_run_in_i,
    input wire logic         rev_run_in_i,
    input wire logic         ext_fault_in_i,
    input wire logic         fault_clear_in_i,
    input wire logic         coast_stop_in_i,
    // feedback and register port
    input wire logic [W-1:0] out_freq_i,
    input wire logic [W-1:0] out_load_i,
    input wire logic [3:0]   reg_addr_i,
    input wire logic [W-1:0] reg_wdata_i,
    input wire logic         reg_wr_i,
    input wire logic         reg_rd_i,
    // outputs
    input wire logic [W-1:0] reg_rdata_o,
    input wire logic         drive_en_o,
    input wire logic [7:0]   fault_code_o,
    input wire logic         freq_reached_out_o,
    input wire logic         overload_warn_out_o,
    input wire logic         fault_relay_no_o,
    input wire logic         fault_relay_nc_o,
    input wire logic         run_relay_no_o,
    input wire logic         run_relay_nc_o
);
    // ==========================================
    // level shadows; settings are written only while clk_en_i is high, internal reset lags so wait
    logic [7:0]   rdy_q;
    logic [W-1:0] det_q;
    logic [W-1:0] ovl_q;
    wire          det_hit = out_freq_i > det_q;
    wire          ovl_hit = out_load_i > ovl_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdy_q <= 8'h00;
            det_q <= '0;
            ovl_q <= '0;
        end else begin
            rdy_q <= {rdy_q[6:0], 1'b1};
            if (reg_wr_i && reg_addr_i == `DTIO_OFF_DET_FREQ) det_q <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == `DTIO_OFF_OVL_LVL) ovl_q <= reg_wdata_i;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i || !rdy_q[7]);
    sequence s_fault_held; ext_fault_in_i[*8]; endsequence
    sequence s_tripped; fault_relay_no_o && !drive_en_o; endsequence
    sequence s_coast_held; coast_stop_in_i[*8]; endsequence
    sequence s_both_held; (fwd_run_in_i && rev_run_in_i)[*8]; endsequence
    a_fault_nc_inverse: assert property (fault_relay_nc_o == !fault_relay_no_o)
        else $error("fault relay contacts not complementary");
    a_run_nc_inverse: assert property (run_relay_nc_o == !run_relay_no_o)
        else $error("run relay contacts not complementary");
    a_trip_code_shown: assert property (fault_relay_no_o |-> fault_code_o == `DTIO_FAULT_EXT)
        else $error("trip without external fault code");
    a_fault_trips_drive: assert property (s_fault_held |-> ##[1:8] s_tripped)
        else $error("held external fault did not trip");
    a_trip_stays_latched: assert property ($fell(fault_relay_no_o) |->
        $past(fault_clear_in_i, 2) && !$past(ext_fault_in_i, 2))
        else $error("trip released without clear");
    a_coast_stops_drive: assert property (s_coast_held |-> ##[1:8] !drive_en_o)
        else $error("coast did not remove drive");
    a_both_dirs_stop: assert property (s_both_held |-> ##[1:8] !drive_en_o)
        else $error("forward with reverse kept driving");
    a_freq_reached_lvl: assert property (freq_reached_out_o == $past(det_hit))
        else $error("frequency reached wrong");
    a_overload_lvl: assert property (overload_warn_out_o == $past(ovl_hit))
        else $error("overload warning wrong");
    a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read slot");
endmodule : dtio_top_chk
bind dtio_top dtio_top_chk #(.W(W), .DEB_CNT(DEB_CNT)) u_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .fwd_run_in_i(fwd_run_in_i), .rev_run_in_i(rev_run_in_i),
    .ext_fault_in_i(ext_fault_in_i), .fault_clear_in_i(fault_clear_in_i), .coast_stop_in_i(coast_stop_in_i),
    .out_freq_i(out_freq_i), .out_load_i(out_load_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .drive_en_o(drive_en_o),
    .fault_code_o(fault_code_o), .freq_reached_out_o(freq_reached_out_o),
    .overload_warn_out_o(overload_warn_out_o), .fault_relay_no_o(fault_relay_no_o),
    .fault_relay_nc_o(fault_relay_nc_o), .run_relay_no_o(run_relay_no_o), .run_relay_nc_o(run_relay_nc_o)
);
`default_nettype wire

// ---- tb_drive_terminal_io_logic.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "dtio_map.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module tb_drive_terminal_io_logic;
    localparam int DEB    = 4;
    localparam int SETTLE = 3 + DEB + 8;
    logic        clk, rst_b, wr, rd, en, rev, zs, frch, ovw, fno, fnc, rno, rnc, ce;
    logic [7:0]  want, c, code;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, freq, load, fcmd;
    int          bad_count, total_checks;
    dtio_top #(.W(16), .DEB_CNT(DEB)) DUT (
        .clk_i(clk), .rst_b_i(rst_b), .clk_en_i(ce), .fwd_run_in_i(c[0]), .rev_run_in_i(c[1]),
        .ext_fault_in_i(c[2]), .fault_clear_in_i(c[3]), .speed_sel0_in_i(c[4]), .speed_sel1_in_i(c[5]),
        .inch_in_i(c[6]), .coast_stop_in_i(c[7]), .out_freq_i(freq), .out_load_i(load),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .drive_en_o(en), .drive_rev_o(rev), .freq_cmd_o(fcmd), .fault_code_o(code),
        .zero_speed_out_o(zs), .freq_reached_out_o(frch), .overload_warn_out_o(ovw),
        .fault_relay_no_o(fno), .fault_relay_nc_o(fnc), .run_relay_no_o(rno), .run_relay_nc_o(rnc));
    dtio_contact_model #(.BOUNCE(3)) u_contacts (.clk_i(clk), .want_i(want), .contact_o(c));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [15:0] pre(input int i);
        return 16'h0111 << i;
    endfunction : pre
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rd_reg
    // debounce needs sync plus stable count plus the chatter of the contact
    task automatic contacts(input logic [7:0] w);
        want <= w;
        repeat (SETTLE) @(posedge clk);
        #1;
    endtask : contacts
    task automatic fb_chk(input logic [15:0] f, input logic [15:0] l, input logic [3:0] e);
        freq <= f;
        load <= l;
        repeat (2) @(posedge clk);
        #1;
        `CHK({zs, frch, rno, ovw}, e)
    endtask : fb_chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        {rst_b, wr, rd, addr, wdata, freq, load, want} = '0;
        ce = 1'b1;
        bad_count = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK({fno, fnc, rno, rnc}, 4'h5)
        for (int i = 0; i < 16; i++) rd_reg(4'(i), 16'h0000);
        wr_reg(`DTIO_OFF_STATUS, 16'hffff);
        rd_reg(`DTIO_OFF_STATUS, 16'h0000);
        wr_reg(`DTIO_OFF_CTRL, 16'hbeef);
        rd_reg(`DTIO_OFF_CTRL, 16'h0000);
        wr_reg(`DTIO_OFF_ZERO_LVL, 16'h0010);
        wr_reg(`DTIO_OFF_DET_FREQ, 16'h0100);
        wr_reg(`DTIO_OFF_OVL_LVL, 16'h0200);
        wr_reg(`DTIO_OFF_RUN_LVL, 16'h0080);
        wr_reg(`DTIO_OFF_INCH, 16'h0555);
        for (int i = 0; i < 4; i++) wr_reg(4'(5 + i), pre(i));
        for (int i = 0; i < 4; i++) rd_reg(4'(5 + i), pre(i));
        rd_reg(`DTIO_OFF_OVL_LVL, 16'h0200);
        contacts(8'h01);
        `CHK({en, rev}, 2'b10)
        rd_reg(`DTIO_OFF_STATUS, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            contacts(8'h01 | 8'(i << 4));
            `CHK(fcmd, pre(i))
        end
        contacts(8'h41);
        `CHK(fcmd, 16'h0555)
        fb_chk(16'h0180, 16'h0201, 4'b0111);
        fb_chk(16'h0100, 16'h0200, 4'b0010);
        fb_chk(16'h0008, 16'h0000, 4'b1000);
        contacts(8'h00);
        `CHK({en, zs}, 2'b01)
        contacts(8'h02);
        `CHK({en, rev}, 2'b11)
        rd_reg(`DTIO_OFF_STATUS, 16'h0003);
        contacts(8'h03);
        `CHK(en, 1'b0)
        contacts(8'h02);
        `CHK({en, rev}, 2'b11)
        contacts(8'h00);
        `CHK(en, 1'b0)
        contacts(8'h01);
        contacts(8'h81);
        `CHK(en, 1'b0)
        contacts(8'h01);
        `CHK(en, 1'b1)
        // frozen while the clock enable is low, then catches up
        ce <= 1'b0;
        contacts(8'h00);
        `CHK(en, 1'b1)
        ce <= 1'b1;
        contacts(8'h00);
        `CHK(en, 1'b0)
        contacts(8'h05);
        `CHK({en, fno, fnc, code}, {3'b010, 8'h1d})
        rd_reg(`DTIO_OFF_STATUS, 16'h1d04);
        contacts(8'h01);
        `CHK({fno, fnc}, 2'b10)
        contacts(8'h0d);
        `CHK({fno, fnc}, 2'b10)
        contacts(8'h08);
        `CHK({fno, fnc}, 2'b01)
        contacts(8'h01);
        rst_b <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({en, fno, fnc}, 3'b001)
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(`DTIO_OFF_DET_FREQ, 16'h0000);
        report_and_stop();
    end
endmodule : tb_drive_terminal_io_logic
`default_nettype wire
